// ==== hdl/sac_top.v ====
// Successive-approximation converter control with its AHB-Lite register slave.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "sac_regs.vh"

// Function
// - High register holds result bits nine to two.
// - Low register holds bits one, zero; rest zero.
// - Overrange input saturates result to all ones.
// - Underrange input gives result zero.
// - Four-bit binary field selects inputs zero to fifteen.
// - Control: flag, speed, on, reserved zero, select.
// - On bit starts continuous back-to-back conversions.
// - Clearing on bit aborts and powers down.
// - Completion writes result and sets flag.
// - Reading high register clears flag; low does not.
// - Any control write clears the flag.
// - Flag bit is read-only; reserved bit reads zero; others read-write.
// - Converter clock is system clock over four or two.
// - Select change restarts conversion, clears flag.
// - Each completion overwrites both result registers.
// - Wait state leaves conversion untouched.
// - Halt disables; wake needs stabilization before converting.
// - Registers at seventy, seventy-one, seventy-two; reset zero.
module sac_top #(
    parameter SAMPLE_TICKS  = `SAC_SAMPLE_TICKS,
    parameter STEP_TICKS    = `SAC_STEP_TICKS,
    parameter WAKE_STAB_CYC = `SAC_WAKE_STAB_CYC
) (
    input  wire        i_clock,          // System clock, 25 MHz.
    input  wire        i_rst_n,          // Synchronous reset, active low.
    input  wire        i_hsel,           // AHB slave select.
    input  wire [31:0] i_haddr,          // AHB byte address.
    input  wire [1:0]  i_htrans,         // AHB transfer type.
    input  wire        i_hwrite,         // AHB write when high.
    input  wire [2:0]  i_hsize,          // AHB transfer size, word only.
    input  wire [31:0] i_hwdata,         // AHB write data.
    input  wire        i_hready,         // AHB bus ready.
    output reg  [31:0] o_hrdata,         // AHB read data.
    output reg         o_hreadyout,      // AHB slave ready.
    output reg         o_hresp,          // AHB response, always OKAY.
    input  wire        i_halt,           // Processor halt state, active high.
    input  wire        i_compare,        // Comparator: input at or above trial code.
    output reg  [3:0]  o_analog_input,   // Analog input multiplexer select.
    output reg         o_analog_enable,  // Analog core power enable.
    output reg         o_sample,         // Sample-and-hold tracking phase.
    output reg  [9:0]  o_trial_code      // Trial code to the comparison DAC.
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_STAB   = 2'h1;
    localparam ST_SAMPLE = 2'h2;
    localparam ST_CONV   = 2'h3;
    localparam [7:0] CTRL_RST = `SAC_CTRL_RST;

    // Decodes a byte address into a register select; used in the address phase of reads and writes.
    function [1:0] reg_decode;
        input [31:0] addr;
        begin
            if (addr[11:0] == {2'b00, `SAC_IDX_CTRL, 2'b00})
                reg_decode = `SAC_SEL_CTRL;
            else if (addr[11:0] == {2'b00, `SAC_IDX_HIGH, 2'b00})
                reg_decode = `SAC_SEL_HIGH;
            else if (addr[11:0] == {2'b00, `SAC_IDX_LOW, 2'b00})
                reg_decode = `SAC_SEL_LOW;
            else
                reg_decode = `SAC_SEL_NONE;
        end
    endfunction

    // Register state.
    reg                  eoc_r;
    reg                  eoc_nxt;
    reg                  speed_r;
    reg                  on_r;
    reg [3:0]            chan_r;
    reg [`SAC_RES_W-1:0] result_r;

    // Bus state.
    reg                  wr_pend_r;
    reg [1:0]            wr_sel_r;
    reg                  rd_pend_r;
    reg [1:0]            rd_sel_r;

    // Converter state.
    reg [1:0]            state_r;
    reg [`SAC_TICK_W-1:0] tick_cnt_r;
    reg [`SAC_RES_W-1:0] mask_r;
    reg [`SAC_RES_W-1:0] trial_r;
    reg [`SAC_STAB_W-1:0] stab_cnt_r;
    reg                  need_stab_r;
    reg                  done_r;

    // Comparator synchroniser and filter.
    reg                  cmp_s1_r;
    reg                  cmp_s2_r;
    reg                  cmp_s3_r;
    reg                  cmp_filt_r;

    wire                 tick_w;
    wire                 run_w;
    wire                 accept_w;
    wire                 rd_now_w;
    wire                 rd_late_w;
    wire [1:0]           rd_sel_w;
    wire                 ctrl_wr_w;
    wire                 high_rd_w;
    wire                 restart_w;
    wire [`SAC_RES_W-1:0] kept_w;
    reg  [31:0]          rdata_w;

    assign accept_w  = i_hsel && i_htrans[1] && i_hready;
    // A read behind a write waits one cycle so that it sees the written value.
    assign rd_now_w  = accept_w && !i_hwrite && !wr_pend_r;
    assign rd_late_w = rd_pend_r;
    assign rd_sel_w  = rd_pend_r ? rd_sel_r : reg_decode(i_haddr);
    assign ctrl_wr_w = wr_pend_r && (wr_sel_r == `SAC_SEL_CTRL);
    assign high_rd_w = (rd_now_w || rd_late_w) && (rd_sel_w == `SAC_SEL_HIGH);

    assign run_w = on_r && !i_halt;

    assign restart_w = ctrl_wr_w && run_w &&
                       (i_hwdata[`SAC_CH_MSB:`SAC_CH_LSB] != chan_r);

    assign kept_w = cmp_filt_r ? trial_r : (trial_r & ~mask_r);

    sac_clk_div #(
        .DIV_SLOW (`SAC_DIV_SLOW),
        .DIV_FAST (`SAC_DIV_FAST)
    ) u_div (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_enable  (run_w),
        .i_fast    (speed_r),
        .i_restart (restart_w),
        .o_tick    (tick_w)
    );

    // Read data mux.
    always @* begin
        rdata_w = 32'h0000_0000;
        case (rd_sel_w)
            `SAC_SEL_CTRL: rdata_w = {24'h00_0000, eoc_r, speed_r, on_r, 1'b0, chan_r};
            `SAC_SEL_HIGH: rdata_w = {24'h00_0000, result_r[9:2]};
            `SAC_SEL_LOW:  rdata_w = {24'h00_0000, 6'b00_0000, result_r[1:0]};
            default:       rdata_w = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave: zero-wait reads, one wait state for a read right after a write.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            wr_pend_r   <= 1'b0;
            wr_sel_r    <= `SAC_SEL_NONE;
            rd_pend_r   <= 1'b0;
            rd_sel_r    <= `SAC_SEL_NONE;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hresp   <= 1'b0;
            wr_pend_r <= accept_w && i_hwrite;
            if (accept_w && i_hwrite)
                wr_sel_r <= reg_decode(i_haddr);
            if (rd_late_w) begin
                rd_pend_r   <= 1'b0;
                o_hrdata    <= rdata_w;
                o_hreadyout <= 1'b1;
            end else if (accept_w && !i_hwrite && wr_pend_r) begin
                rd_pend_r   <= 1'b1;
                rd_sel_r    <= reg_decode(i_haddr);
                o_hreadyout <= 1'b0;
            end else if (rd_now_w) begin
                o_hrdata    <= rdata_w;
                o_hreadyout <= 1'b1;
            end else begin
                o_hreadyout <= 1'b1;
            end
        end
    end

    // Flag update: a completion in the same cycle as a clear keeps the flag set.
    // Polled flag, no interrupt
    always @* begin
        eoc_nxt = eoc_r;
        if (high_rd_w)
            eoc_nxt = 1'b0;
        if (ctrl_wr_w)
            eoc_nxt = 1'b0;
        if (done_r)
            eoc_nxt = 1'b1;
    end

    // Control and result registers.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            eoc_r    <= CTRL_RST[`SAC_EOC_BIT];
            speed_r  <= CTRL_RST[`SAC_SPEED_BIT];
            on_r     <= CTRL_RST[`SAC_ON_BIT];
            chan_r   <= CTRL_RST[`SAC_CH_MSB:`SAC_CH_LSB];
            result_r <= `SAC_RES_RST;
        end else begin
            eoc_r <= eoc_nxt;
            if (ctrl_wr_w) begin
                speed_r <= i_hwdata[`SAC_SPEED_BIT];
                on_r    <= i_hwdata[`SAC_ON_BIT];
                chan_r  <= i_hwdata[`SAC_CH_MSB:`SAC_CH_LSB];
            end
            if (done_r)
                result_r <= kept_w;
        end
    end

    // Comparator crossing: the filtered level moves only when stages two and three agree.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            cmp_s1_r   <= 1'b0;
            cmp_s2_r   <= 1'b0;
            cmp_s3_r   <= 1'b0;
            cmp_filt_r <= 1'b0;
        end else begin
            cmp_s1_r <= i_compare;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            if (cmp_s2_r == cmp_s3_r)
                cmp_filt_r <= cmp_s3_r;
        end
    end

    // Conversion sequencer. The comparator path adds about four cycles of latency,
    // so a step must last longer than that; the tick defaults keep a margin at both speeds.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_r     <= ST_IDLE;
            tick_cnt_r  <= {`SAC_TICK_W{1'b0}};
            mask_r      <= `SAC_RES_MSB_INIT;
            trial_r     <= `SAC_RES_RST;
            stab_cnt_r  <= {`SAC_STAB_W{1'b0}};
            need_stab_r <= 1'b0;
            done_r      <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (i_halt)
                need_stab_r <= 1'b1;
            if (!run_w) begin
                state_r    <= ST_IDLE;
                tick_cnt_r <= {`SAC_TICK_W{1'b0}};
            end else if (restart_w && (state_r != ST_STAB)) begin
                state_r    <= ST_SAMPLE;
                tick_cnt_r <= {`SAC_TICK_W{1'b0}};
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        tick_cnt_r <= {`SAC_TICK_W{1'b0}};
                        if (need_stab_r) begin
                            state_r    <= ST_STAB;
                            stab_cnt_r <= WAKE_STAB_CYC[`SAC_STAB_W-1:0];
                        end else begin
                            state_r <= ST_SAMPLE;
                        end
                    end
                    ST_STAB: begin
                        if (stab_cnt_r <= {{(`SAC_STAB_W-1){1'b0}}, 1'b1}) begin
                            need_stab_r <= 1'b0;
                            state_r     <= ST_SAMPLE;
                        end else begin
                            stab_cnt_r <= stab_cnt_r - {{(`SAC_STAB_W-1){1'b0}}, 1'b1};
                        end
                    end
                    ST_SAMPLE: begin
                        if (tick_w) begin
                            if (tick_cnt_r == SAMPLE_TICKS[`SAC_TICK_W-1:0] - 1'b1) begin
                                state_r    <= ST_CONV;
                                tick_cnt_r <= {`SAC_TICK_W{1'b0}};
                                mask_r     <= `SAC_RES_MSB_INIT;
                                trial_r    <= `SAC_RES_MSB_INIT;
                            end else begin
                                tick_cnt_r <= tick_cnt_r + 1'b1;
                            end
                        end
                    end
                    ST_CONV: begin
                        if (tick_w) begin
                            if (tick_cnt_r == STEP_TICKS[`SAC_TICK_W-1:0] - 1'b1) begin
                                tick_cnt_r <= {`SAC_TICK_W{1'b0}};
                                if (mask_r[0]) begin
                                    done_r  <= 1'b1;
                                    state_r <= ST_SAMPLE;
                                end else begin
                                    trial_r <= kept_w | (mask_r >> 1);
                                    mask_r  <= mask_r >> 1;
                                end
                            end else begin
                                tick_cnt_r <= tick_cnt_r + 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Analog-side outputs, all registered.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_analog_input  <= 4'h0;
            o_analog_enable <= 1'b0;
            o_sample        <= 1'b0;
            o_trial_code    <= `SAC_RES_RST;
        end else begin
            o_analog_input  <= chan_r;
            o_analog_enable <= run_w;
            o_sample        <= run_w && (state_r == ST_SAMPLE) && !restart_w;
            o_trial_code    <= (state_r == ST_CONV) ? trial_r : `SAC_RES_RST;
        end
    end

endmodule // sac_top

// ==== hdl/sac_regs.vh ====
// Register map, field positions, reset values and timing counts of the converter control.
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define SAC_IDX_CTRL        8'h70
`define SAC_IDX_HIGH        8'h71
`define SAC_IDX_LOW         8'h72

// Register select codes produced by the address decoder.
`define SAC_SEL_NONE        2'h0
`define SAC_SEL_CTRL        2'h1
`define SAC_SEL_HIGH        2'h2
`define SAC_SEL_LOW         2'h3

// Control and status field positions.
`define SAC_EOC_BIT         7
`define SAC_SPEED_BIT       6
`define SAC_ON_BIT          5
`define SAC_RSVD_BIT        4
`define SAC_CH_MSB          3
`define SAC_CH_LSB          0

// Reset values.
`define SAC_CTRL_RST        8'h00
`define SAC_HIGH_RST        8'h00
`define SAC_LOW_RST         8'h00
`define SAC_RES_RST         10'h000

// Result layout.
`define SAC_RES_W           10
`define SAC_RES_MSB_INIT    10'h200

// Converter clock dividers, slow (speed bit 0) and fast (speed bit 1).
`define SAC_DIV_SLOW        4
`define SAC_DIV_FAST        2

// Conversion timing in converter clock ticks.
`define SAC_SAMPLE_TICKS    4
`define SAC_STEP_TICKS      4
`define SAC_TICK_W          4

// Wake stabilization time after halt, in ns, and its cycle count at the system clock.
`define SAC_CLK_MHZ         25
`define SAC_WAKE_STAB_NS    1000
`define SAC_WAKE_STAB_CYC   ((`SAC_WAKE_STAB_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_STAB_W          16

`endif

// ==== hdl/sac_clk_div.v ====
// Converter clock enable divider: one tick every two or four system clocks.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_clk_div #(
    parameter DIV_SLOW = `SAC_DIV_SLOW,
    parameter DIV_FAST = `SAC_DIV_FAST
) (
    input  wire i_clock,    // System clock.
    input  wire i_rst_n,    // Synchronous reset, active low.
    input  wire i_enable,   // Divider runs while high.
    input  wire i_fast,     // High selects the fast division.
    input  wire i_restart,  // Realigns the tick phase.
    output reg  o_tick      // One-cycle converter clock enable.
);

    reg [2:0] cnt_r;
    wire [2:0] last_w;

    assign last_w = i_fast ? DIV_FAST[2:0] - 3'h1 : DIV_SLOW[2:0] - 3'h1;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            cnt_r  <= 3'h0;
            o_tick <= 1'b0;
        end else if (!i_enable || i_restart) begin
            cnt_r  <= 3'h0;
            o_tick <= 1'b0;
        end else if (cnt_r >= last_w) begin
            // A speed change mid-count ends the period at once rather than overrunning.
            cnt_r  <= 3'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 3'h1;
            o_tick <= 1'b0;
        end
    end

endmodule // sac_clk_div

// ==== sim/sac_props.sv ====
// Concurrent checks on the converter control ports.
`timescale 1ns/1ps
module sac_props (
    input wire        i_clock,         // System clock.
    input wire        i_rst_n,         // Synchronous reset, active low.
    input wire        i_hsel,          // AHB select.
    input wire [31:0] i_haddr,         // AHB address.
    input wire [1:0]  i_htrans,        // AHB transfer type.
    input wire        i_hwrite,        // AHB write.
    input wire [31:0] i_hwdata,        // AHB write data.
    input wire        i_hready,        // AHB ready.
    input wire [31:0] o_hrdata,        // AHB read data.
    input wire        o_hreadyout,     // AHB slave ready.
    input wire        o_hresp,         // AHB response.
    input wire        i_halt,          // Halt state.
    input wire [3:0]  o_analog_input,  // Multiplexer select.
    input wire        o_analog_enable, // Core enable.
    input wire        o_sample,        // Tracking phase.
    input wire [9:0]  o_trial_code     // Trial code.
);
    reg       wr_pend_r;
    reg [7:0] wr_byte_r;
    wire      rd_low = i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[11:0] == 12'h1C8;

    // The data byte is caught at the data phase so later checks can compare against it.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            wr_pend_r <= 1'b0;
            wr_byte_r <= 8'h00;
        end else begin
            wr_pend_r <= i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr[11:0] == 12'h1C0;
            if (wr_pend_r) begin
                wr_byte_r <= i_hwdata[7:0];
            end
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_low_upper_zero: assert property (rd_low |-> ##[1:2]
        (o_hreadyout && o_hrdata[31:2] == 30'h0)) else $error("low read shows upper bits");
    a_rdata_byte_wide: assert property (o_hrdata[31:8] == 24'h0)
        else $error("read data above byte set");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("slave response not okay");
    a_on_enables: assert property (wr_pend_r && !i_halt |=> ##[1:2]
        (o_analog_enable == wr_byte_r[5])) else $error("enable does not follow on bit");
    a_input_select: assert property (wr_pend_r |=> ##[1:2]
        (o_analog_input == wr_byte_r[3:0])) else $error("select does not follow write");
    a_halt_disables: assert property (i_halt |=> !o_analog_enable)
        else $error("core enabled in halt");
    a_sample_no_trial: assert property (o_sample |-> o_trial_code == 10'h000)
        else $error("trial code during sampling");
    a_msb_first: assert property ($past(o_trial_code) == 10'h000 && o_trial_code != 10'h000
        |-> o_trial_code == 10'h200) else $error("first step not msb");
    a_step_spacing: assert property ($changed(o_trial_code) && o_trial_code != 10'h000
        |=> ($stable(o_trial_code) || o_trial_code == 10'h000) [*7]) else $error("step too short");
endmodule // sac_props

bind sac_top sac_props sac_props_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_halt(i_halt),
    .o_analog_input(o_analog_input), .o_analog_enable(o_analog_enable), .o_sample(o_sample),
    .o_trial_code(o_trial_code));

// ==== sim/sac_analog_model.sv ====
// Behavioural analog core: input levels, sample-and-hold and comparator.
`timescale 1ns/1ps
module sac_analog_model (
    input  wire       i_clock,   // System clock.
    input  wire [3:0] i_sel,     // Input multiplexer select.
    input  wire       i_enable,  // Core power enable.
    input  wire       i_sample,  // Tracking phase.
    input  wire [9:0] i_trial,   // Trial code.
    output wire       o_compare  // High when held level is at or above trial.
);
    reg [9:0] level [0:15];
    reg [9:0] held_r;
    integer   k;

    initial begin
        for (k = 0; k < 16; k = k + 1) begin
            level[k] = k[9:0] * 10'h043;
        end
        level[1] = 10'h3FF;
        held_r = 10'h000;
    end

    always @(posedge i_clock) begin
        if (i_sample) begin
            held_r <= level[i_sel];
        end
    end

    assign o_compare = i_enable && (held_r >= i_trial);
endmodule // sac_analog_model

// ==== sim/sac_top_tb.sv ====
// Register-level test sequence for the converter control.
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_top_tb;
    localparam [31:0] A_CTRL = {22'h0, `SAC_IDX_CTRL, 2'b00};
    localparam [31:0] A_HIGH = {22'h0, `SAC_IDX_HIGH, 2'b00};
    localparam [31:0] A_LOW  = {22'h0, `SAC_IDX_LOW, 2'b00};
    localparam [31:0] A_NONE = 32'h0000_01CC;
    reg         i_clock, i_rst_n, i_hsel, i_hwrite, i_halt;
    reg  [31:0] i_haddr, i_hwdata, d, cw;
    reg  [1:0]  i_htrans;
    reg  [2:0]  i_hsize;
    reg  [9:0]  v;
    reg  [3:0]  ch;
    wire [31:0] o_hrdata;
    wire        o_hreadyout, o_hresp, o_analog_enable, o_sample, i_compare;
    wire [3:0]  o_analog_input;
    wire [9:0]  o_trial_code;
    integer     error_cnt, n_compared, cyc, t0, k;

    sac_top #(.WAKE_STAB_CYC(3)) sac_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_halt(i_halt), .i_compare(i_compare),
        .o_analog_input(o_analog_input), .o_analog_enable(o_analog_enable),
        .o_sample(o_sample), .o_trial_code(o_trial_code));
    sac_analog_model sac_analog_model_inst (.i_clock(i_clock), .i_sel(o_analog_input),
        .i_enable(o_analog_enable), .i_sample(o_sample), .i_trial(o_trial_code),
        .o_compare(i_compare));

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // The ceiling sits well above the two thousand or so cycles the sequence needs.
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        begin
            if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    task bus(input w, input [31:0] a, input [31:0] wd);
        begin
            @(posedge i_clock);
            i_hsel <= 1'b1;
            i_htrans <= 2'b10;
            i_haddr <= a;
            i_hwrite <= w;
            @(posedge i_clock);
            while (o_hreadyout !== 1'b1) @(posedge i_clock);
            i_hsel <= 1'b0;
            i_htrans <= 2'b00;
            i_hwdata <= wd;
            @(posedge i_clock);
            while (o_hreadyout !== 1'b1) @(posedge i_clock);
            d = o_hrdata;
        end
    endtask

    task chk(input [8*12:1] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task chk_rng(input [8*12:1] nm, input integer lo, input integer hi, input integer g);
        begin
            n_compared = n_compared + 1;
            if (g < lo || g > hi) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s expected %0d..%0d seen %0d", nm, lo, hi, g);
            end
        end
    endtask

    task rc(input [31:0] a, input [31:0] e, input [8*12:1] nm);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(nm, e, d);
        end
    endtask

    // Polling leans on the bench ceiling rather than its own limit.
    task eoc;
        begin
            bus(1'b0, A_CTRL, 32'h0000_0000);
            while (d[7] !== 1'b1) bus(1'b0, A_CTRL, 32'h0000_0000);
        end
    endtask

    initial begin
        {i_rst_n, i_hsel, i_hwrite, i_halt, i_htrans, i_haddr, i_hwdata} = 0;
        i_hsize = 3'b010;
        {error_cnt, n_compared, cyc} = 0;
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rc(A_CTRL, 32'h0000_0000, "ctrl_rst");
        rc(A_HIGH, 32'h0000_0000, "high_rst");
        rc(A_LOW, 32'h0000_0000, "low_rst");
        bus(1'b1, A_CTRL, 32'h0000_00FF);
        rc(A_CTRL, 32'h0000_006F, "ctrl_rw");
        bus(1'b1, A_NONE, 32'h0000_00FF);
        rc(A_NONE, 32'h0000_0000, "unmapped");
        bus(1'b1, A_CTRL, 32'h0000_0000);
        for (k = 0; k < 4; k = k + 1) begin
            ch = (k == 3) ? 4'hF : (k == 2) ? 4'h5 : k[3:0];
            v = (ch == 4'h1) ? 10'h3FF : {6'h00, ch} * 10'h043;
            cw = {25'h0, k[0], 2'b10, ch};
            bus(1'b1, A_CTRL, cw);
            t0 = cyc;
            eoc;
            if (k[0]) chk_rng("fast_time", 86, 102, cyc - t0);
            else chk_rng("slow_time", 174, 192, cyc - t0);
            rc(A_LOW, {30'h0, v[1:0]}, "low");
            rc(A_CTRL, cw | 32'h0000_0080, "eoc_kept");
            rc(A_HIGH, {24'h0, v[9:2]}, "high");
            rc(A_CTRL, cw, "eoc_clear");
        end
        eoc;
        bus(1'b1, A_CTRL, 32'h0000_006F);
        rc(A_CTRL, 32'h0000_006F, "wr_clear");
        bus(1'b1, A_CTRL, 32'h0000_0065);
        repeat (40) @(posedge i_clock);
        bus(1'b1, A_CTRL, 32'h0000_006F);
        t0 = cyc;
        eoc;
        chk_rng("restart", 86, 102, cyc - t0);
        rc(A_HIGH, {24'h0, v[9:2]}, "high_only");
        sac_analog_model_inst.level[15] = 10'h2AA;
        eoc;
        bus(1'b0, A_HIGH, 32'h0000_0000);
        eoc;
        rc(A_HIGH, 32'h0000_00AA, "overwrite");
        bus(1'b1, A_CTRL, 32'h0000_000F);
        repeat (300) @(posedge i_clock);
        rc(A_CTRL, 32'h0000_000F, "off_idle");
        bus(1'b1, A_CTRL, 32'h0000_0021);
        repeat (20) @(posedge i_clock);
        i_halt <= 1'b1;
        repeat (50) @(posedge i_clock);
        i_halt <= 1'b0;
        eoc;
        rc(A_HIGH, 32'h0000_00FF, "after_halt");
        tally_and_finish;
    end
endmodule // sac_top_tb
